/* File: verilog/rwp_pkg.sv */
// package for the ram window and pattern command block
// assumes command and parameter bytes arrive as one-cycle strobes
package rwp_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_OPT = 8'h41;
  localparam logic [7:0] CMD_X_WIN = 8'h44;
  localparam logic [7:0] CMD_Y_WIN = 8'h45;
  localparam logic [7:0] CMD_FILL_RED = 8'h46;
  localparam logic [7:0] CMD_FILL_BW = 8'h47;
  localparam logic [7:0] CMD_X_CNT = 8'h4E;
  localparam logic [7:0] CMD_Y_CNT = 8'h4F;
  // reset values
  localparam logic [5:0] X_FIRST_RST = 6'h00;
  localparam logic [5:0] X_LAST_RST = 6'h15;
  localparam logic [8:0] Y_FIRST_RST = 9'h000;
  localparam logic [8:0] Y_LAST_RST = 9'h0C7;
  localparam logic [7:0] FILL_PARAM_RST = 8'h00;
  localparam logic [5:0] X_CNT_RST = 6'h00;
  localparam logic [8:0] Y_CNT_RST = 9'h000;
  // step sizes in pixels for the 3-bit step code, codes 5 to 7 all giving 200
  localparam logic [8:0] STEP_8 = 9'h008;
  localparam logic [8:0] STEP_16 = 9'h010;
  localparam logic [8:0] STEP_32 = 9'h020;
  localparam logic [8:0] STEP_64 = 9'h040;
  localparam logic [8:0] STEP_128 = 9'h080;
  localparam logic [8:0] STEP_200 = 9'h0C8;
  // pattern field positions
  localparam int FILL_VAL_BIT = 7;
  localparam int FILL_H_HI = 6;
  localparam int FILL_H_LO = 4;
  localparam int FILL_W_HI = 2;
  localparam int FILL_W_LO = 0;
  // panel geometry in pixels
  localparam logic [8:0] PANEL_W = 9'h0C8;
  localparam logic [8:0] PANEL_H = 9'h0C8;
  localparam logic [8:0] ONE9 = 9'h001;
  // parameter byte index values
  localparam logic [1:0] IDX0 = 2'h0;
  localparam logic [1:0] IDX1 = 2'h1;
  localparam logic [1:0] IDX2 = 2'h2;
  localparam logic [1:0] IDX3 = 2'h3;
  // fill engine states
  typedef enum logic [1:0] {
    RWP_IDLE = 2'b00,
    RWP_FILL = 2'b01
  } rwp_state_t;
endpackage

/* File: verilog/rwp_core.sv */
// ram window, read option, pattern fill and address counter commands
// assumes synchronous cmd/data strobes from a serial front end and a
// one-bit-per-cycle ram write port owned by this block during fills
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module rwp_core (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cmd_stb,
  input wire logic data_stb,
  input wire logic [7:0] byte_in,
  input wire logic ram_access,
  output logic read_plane_r,
  output logic [5:0] x_window_first_field_r,
  output logic [5:0] x_window_last_field_r,
  output logic [8:0] y_window_first_r,
  output logic [8:0] y_window_last_r,
  output logic [5:0] x_cnt_r,
  output logic [8:0] y_cnt_r,
  output logic busy_r,
  output logic fill_we_r,
  output logic fill_plane_r,
  output logic [8:0] fill_x_r,
  output logic [8:0] fill_y_r,
  output logic fill_bit_r
);

  ////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;

  // two-flop release of the async reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  ////////////////////////////////////////////////////////////////////
  // step size decode, shared by height and width
  function automatic logic [8:0] step_of(input logic [2:0] code);
    logic [8:0] s;
    s = rwp_pkg::STEP_200;
    case (code)
      3'h0: s = rwp_pkg::STEP_8;
      3'h1: s = rwp_pkg::STEP_16;
      3'h2: s = rwp_pkg::STEP_32;
      3'h3: s = rwp_pkg::STEP_64;
      3'h4: s = rwp_pkg::STEP_128;
      default: s = rwp_pkg::STEP_200;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // command state
  logic [7:0] cmd_r, cmd_nxt; // current command
  logic [1:0] idx_r, idx_nxt; // parameter byte index
  logic [7:0] lo_r, lo_nxt; // held low byte
  logic read_plane_nxt;
  logic [5:0] xf_nxt, xl_nxt, xc_nxt;
  logic [8:0] yf_nxt, yl_nxt, yc_nxt;
  logic [7:0] fparam_r, fparam_nxt; // fill parameter
  logic start_fill; // fill launch this cycle
  logic fplane_sel; // plane of launched fill
  logic fill_done; // last pixel written
  rwp_pkg::rwp_state_t st_r, st_nxt;

  // parameter byte handling and counter stepping
  always_comb begin
    cmd_nxt = cmd_r;
    idx_nxt = idx_r;
    lo_nxt = lo_r;
    read_plane_nxt = read_plane_r;
    xf_nxt = x_window_first_field_r;
    xl_nxt = x_window_last_field_r;
    yf_nxt = y_window_first_r;
    yl_nxt = y_window_last_r;
    xc_nxt = x_cnt_r;
    yc_nxt = y_cnt_r;
    fparam_nxt = fparam_r;
    start_fill = 1'b0;
    fplane_sel = 1'b0;
    if (cmd_stb && !busy_r) begin
      // new command restarts parameter count
      cmd_nxt = byte_in;
      idx_nxt = rwp_pkg::IDX0;
    end else if (data_stb && !busy_r) begin
      idx_nxt = (idx_r == rwp_pkg::IDX3) ? idx_r : idx_r + 2'h1;
      case (cmd_r)
        rwp_pkg::CMD_READ_OPT: begin
          if (idx_r == rwp_pkg::IDX0) read_plane_nxt = byte_in[0];
        end
        rwp_pkg::CMD_X_WIN: begin
          if (idx_r == rwp_pkg::IDX0) xf_nxt = byte_in[5:0];
          else if (idx_r == rwp_pkg::IDX1) xl_nxt = byte_in[5:0];
        end
        rwp_pkg::CMD_Y_WIN: begin
          // low byte then bit 8 byte
          if (idx_r == rwp_pkg::IDX0 || idx_r == rwp_pkg::IDX2) begin
            lo_nxt = byte_in;
          end else if (idx_r == rwp_pkg::IDX1) begin
            yf_nxt = {byte_in[0], lo_r};
          end else begin
            yl_nxt = {byte_in[0], lo_r};
          end
        end
        rwp_pkg::CMD_FILL_RED, rwp_pkg::CMD_FILL_BW: begin
          if (idx_r == rwp_pkg::IDX0) begin
            fparam_nxt = byte_in;
            start_fill = 1'b1;
            fplane_sel = (cmd_r == rwp_pkg::CMD_FILL_RED);
          end
        end
        rwp_pkg::CMD_X_CNT: begin
          if (idx_r == rwp_pkg::IDX0) xc_nxt = byte_in[5:0];
        end
        rwp_pkg::CMD_Y_CNT: begin
          if (idx_r == rwp_pkg::IDX0) lo_nxt = byte_in;
          else if (idx_r == rwp_pkg::IDX1) yc_nxt = {byte_in[0], lo_r};
        end
        default: begin
          lo_nxt = lo_r;
        end
      endcase
    end else if (ram_access && !busy_r) begin
      // advance inside the window only, wrap to start
      if (x_cnt_r >= x_window_last_field_r) begin
        xc_nxt = x_window_first_field_r;
        if (y_cnt_r >= y_window_last_r) yc_nxt = y_window_first_r;
        else yc_nxt = y_cnt_r + rwp_pkg::ONE9;
      end else begin
        xc_nxt = x_cnt_r + 6'h01;
      end
    end
  end

  // command registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      idx_r <= rwp_pkg::IDX0;
      lo_r <= 8'h00;
      read_plane_r <= 1'b0;
      x_window_first_field_r <= rwp_pkg::X_FIRST_RST;
      x_window_last_field_r <= rwp_pkg::X_LAST_RST;
      y_window_first_r <= rwp_pkg::Y_FIRST_RST;
      y_window_last_r <= rwp_pkg::Y_LAST_RST;
      x_cnt_r <= rwp_pkg::X_CNT_RST;
      y_cnt_r <= rwp_pkg::Y_CNT_RST;
      fparam_r <= rwp_pkg::FILL_PARAM_RST;
    end else begin
      cmd_r <= cmd_nxt;
      idx_r <= idx_nxt;
      lo_r <= lo_nxt;
      read_plane_r <= read_plane_nxt;
      x_window_first_field_r <= xf_nxt;
      x_window_last_field_r <= xl_nxt;
      y_window_first_r <= yf_nxt;
      y_window_last_r <= yl_nxt;
      x_cnt_r <= xc_nxt;
      y_cnt_r <= yc_nxt;
      fparam_r <= fparam_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fill engine: raster over the panel, one pixel per cycle
  logic [8:0] fx_nxt, fy_nxt; // pixel position
  logic [8:0] sx_r, sx_nxt; // position within step column
  logic [8:0] sy_r, sy_nxt; // position within step row
  logic px_r, px_nxt; // column parity
  logic py_r, py_nxt; // row parity
  logic busy_nxt, we_nxt, plane_nxt, bit_nxt;
  logic [8:0] h_step, w_step;

  assign h_step = step_of(fparam_r[rwp_pkg::FILL_H_HI:rwp_pkg::FILL_H_LO]);
  assign w_step = step_of(fparam_r[rwp_pkg::FILL_W_HI:rwp_pkg::FILL_W_LO]);
  assign fill_done = (fill_x_r == rwp_pkg::PANEL_W - rwp_pkg::ONE9) &&
                     (fill_y_r == rwp_pkg::PANEL_H - rwp_pkg::ONE9);

  // next pixel and its value
  always_comb begin
    st_nxt = st_r;
    fx_nxt = fill_x_r;
    fy_nxt = fill_y_r;
    sx_nxt = sx_r;
    sy_nxt = sy_r;
    px_nxt = px_r;
    py_nxt = py_r;
    plane_nxt = fill_plane_r;
    we_nxt = 1'b0;
    busy_nxt = busy_r;
    case (st_r)
      rwp_pkg::RWP_IDLE: begin
        if (start_fill) begin
          st_nxt = rwp_pkg::RWP_FILL;
          busy_nxt = 1'b1;
          plane_nxt = fplane_sel;
          fx_nxt = 9'h000;
          fy_nxt = 9'h000;
          sx_nxt = 9'h000;
          sy_nxt = 9'h000;
          px_nxt = 1'b0;
          py_nxt = 1'b0;
          we_nxt = 1'b1;
        end
      end
      rwp_pkg::RWP_FILL: begin
        if (fill_done) begin
          st_nxt = rwp_pkg::RWP_IDLE;
          busy_nxt = 1'b0;
        end else begin
          we_nxt = 1'b1;
          if (fill_x_r == rwp_pkg::PANEL_W - rwp_pkg::ONE9) begin
            // end of row: back to column zero
            fx_nxt = 9'h000;
            sx_nxt = 9'h000;
            px_nxt = 1'b0;
            fy_nxt = fill_y_r + rwp_pkg::ONE9;
            if (sy_r == h_step - rwp_pkg::ONE9) begin
              sy_nxt = 9'h000;
              py_nxt = ~py_r;
            end else begin
              sy_nxt = sy_r + rwp_pkg::ONE9;
            end
          end else begin
            fx_nxt = fill_x_r + rwp_pkg::ONE9;
            if (sx_r == w_step - rwp_pkg::ONE9) begin
              sx_nxt = 9'h000;
              px_nxt = ~px_r;
            end else begin
              sx_nxt = sx_r + rwp_pkg::ONE9;
            end
          end
        end
      end
      default: begin
        st_nxt = rwp_pkg::RWP_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    // first step value, alternating per step
    bit_nxt = (start_fill ? fparam_nxt[rwp_pkg::FILL_VAL_BIT]
                          : fparam_r[rwp_pkg::FILL_VAL_BIT]) ^ px_nxt ^ py_nxt;
  end

  // fill registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= rwp_pkg::RWP_IDLE;
      fill_x_r <= 9'h000;
      fill_y_r <= 9'h000;
      sx_r <= 9'h000;
      sy_r <= 9'h000;
      px_r <= 1'b0;
      py_r <= 1'b0;
      busy_r <= 1'b0;
      fill_we_r <= 1'b0;
      fill_plane_r <= 1'b0;
      fill_bit_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fill_x_r <= fx_nxt;
      fill_y_r <= fy_nxt;
      sx_r <= sx_nxt;
      sy_r <= sy_nxt;
      px_r <= px_nxt;
      py_r <= py_nxt;
      busy_r <= busy_nxt;
      fill_we_r <= we_nxt;
      fill_plane_r <= plane_nxt;
      fill_bit_r <= bit_nxt;
    end
  end

endmodule

/* File: sim/rwp_core_assertions.sv */
// port checker for the ram window and pattern command block
// assumes it is bound to rwp_core and sees only its ports
`timescale 1ns/100ps
module rwp_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cmd_stb,
  input wire logic data_stb,
  input wire logic [7:0] byte_in,
  input wire logic ram_access,
  input wire logic read_plane_r,
  input wire logic [5:0] x_window_first_field_r,
  input wire logic [5:0] x_window_last_field_r,
  input wire logic [8:0] y_window_first_r,
  input wire logic [8:0] y_window_last_r,
  input wire logic [5:0] x_cnt_r,
  input wire logic [8:0] y_cnt_r,
  input wire logic busy_r,
  input wire logic fill_we_r,
  input wire logic fill_plane_r,
  input wire logic [8:0] fill_x_r,
  input wire logic [8:0] fill_y_r,
  input wire logic fill_bit_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // command byte taken while idle
  sequence s_cmd(c); !busy_r && cmd_stb && byte_in == c; endsequence
  // parameter byte taken while idle
  sequence s_dat; !busy_r && data_stb && !cmd_stb; endsequence
  // fill starts at once with the first pixel at the origin
  property p_fill(c, pl);
    s_cmd(c) ##1 s_dat |=> busy_r && fill_we_r && fill_plane_r == pl &&
      fill_bit_r == $past(byte_in[7]) && fill_x_r == 9'h000 &&
      fill_y_r == 9'h000;
  endproperty
  ////////////////////////////////////////////////////////////////////
  a_reset_vals: assert property (disable iff (1'b0) !rstn [*3] |->
    x_window_first_field_r == 6'h00 && x_window_last_field_r == 6'h15)
    else $error("window reset values wrong");
  a_read_plane: assert property (s_cmd(8'h41) ##1 s_dat |=>
    read_plane_r == $past(byte_in[0])) else $error("read plane not set");
  a_x_window: assert property (s_cmd(8'h44) ##1 s_dat ##1 s_dat |=>
    x_window_first_field_r == $past(byte_in[5:0], 2) &&
    x_window_last_field_r == $past(byte_in[5:0]))
    else $error("x window not loaded");
  a_y_window: assert property (s_cmd(8'h45) ##1 s_dat [*4] |=>
    y_window_first_r == {$past(byte_in[0], 3), $past(byte_in, 4)} &&
    y_window_last_r == {$past(byte_in[0]), $past(byte_in, 2)})
    else $error("y window not loaded");
  a_x_counter: assert property (s_cmd(8'h4E) ##1 s_dat |=>
    x_cnt_r == $past(byte_in[5:0])) else $error("x counter not loaded");
  a_y_counter: assert property (s_cmd(8'h4F) ##1 s_dat ##1 s_dat |=>
    y_cnt_r == {$past(byte_in[0]), $past(byte_in, 2)})
    else $error("y counter not loaded");
  a_fill_red: assert property (p_fill(8'h46, 1'b1))
    else $error("red fill start wrong");
  a_fill_bw: assert property (p_fill(8'h47, 1'b0))
    else $error("bw fill start wrong");
  a_busy_end: assert property ($fell(busy_r) |->
    $past(fill_x_r) == 9'h0C7 && $past(fill_y_r) == 9'h0C7)
    else $error("busy dropped before last pixel");
  a_busy_refuse: assert property (busy_r |=>
    $stable(x_window_first_field_r) && $stable(x_cnt_r) &&
    $stable(read_plane_r)) else $error("state changed while busy");
  a_x_step: assert property (ram_access && !cmd_stb && !data_stb &&
    !busy_r |=> x_cnt_r == ($past(x_cnt_r) >= $past(x_window_last_field_r) ?
    $past(x_window_first_field_r) : $past(x_cnt_r) + 6'h01))
    else $error("x counter step wrong");
endmodule
bind rwp_core rwp_chk u_chk (.ref_clk, .rstn, .cmd_stb, .data_stb,
  .byte_in, .ram_access, .read_plane_r, .x_window_first_field_r,
  .x_window_last_field_r, .y_window_first_r, .y_window_last_r, .x_cnt_r,
  .y_cnt_r, .busy_r, .fill_we_r, .fill_plane_r, .fill_x_r, .fill_y_r,
  .fill_bit_r);

/* File: sim/rwp_host.sv */
// host controller model issuing command and parameter bytes
// assumes the bench calls its tasks; strobes launch at the falling edge
`timescale 1ns/100ps
module rwp_host (
  input wire logic ref_clk,
  output logic cmd_stb,
  output logic data_stb,
  output logic [7:0] byte_in,
  output logic ram_access
);
  // idle bus at time zero
  initial begin
    cmd_stb = 1'b0;
    data_stb = 1'b0;
    byte_in = 8'h00;
    ram_access = 1'b0;
  end
  // one byte for one cycle, command when dc is low
  task put(input logic dc, input logic [7:0] b);
    @(negedge ref_clk);
    cmd_stb <= !dc;
    data_stb <= dc;
    byte_in <= b;
    ram_access <= 1'b0;
  endtask
  // release; the data line shows the inverse so stale bytes never match
  task idle;
    @(negedge ref_clk);
    cmd_stb <= 1'b0;
    data_stb <= 1'b0;
    ram_access <= 1'b0;
    byte_in <= ~byte_in;
  endtask
  // one ram data access pulse
  task touch;
    @(negedge ref_clk);
    cmd_stb <= 1'b0;
    data_stb <= 1'b0;
    ram_access <= 1'b1;
  endtask
  // command then n parameter bytes back to back, low byte first
  task send(input logic [7:0] c, input logic [31:0] p, input int n);
    put(1'b0, c);
    for (int i = 0; i < n; i++) put(1'b1, p[8*i +: 8]);
    idle();
  endtask
endmodule

/* File: sim/ram_window_pattern_commands_test.sv */
// self-checking bench for the ram window and pattern command block
// assumes rwp_core with its bound checker and the rwp_host model
`timescale 1ns/100ps
module ram_window_pattern_commands_test;
  logic ref_clk, rstn, cmd_stb, data_stb, ram_access, read_plane_r;
  logic [7:0] byte_in, pb;
  logic [5:0] x_window_first_field_r, x_window_last_field_r, x_cnt_r;
  logic [8:0] y_window_first_r, y_window_last_r, y_cnt_r, fill_x_r, fill_y_r;
  logic busy_r, fill_we_r, fill_plane_r, fill_bit_r;
  int fails = 0;
  int check_count = 0;
  int n;
  int wr = 0; // pixel writes seen, counted by the monitor only
  int base = 0; // write count at the start of the current fill
  rwp_core DUT (.ref_clk, .rstn, .cmd_stb, .data_stb, .byte_in, .ram_access,
    .read_plane_r, .x_window_first_field_r, .x_window_last_field_r,
    .y_window_first_r, .y_window_last_r, .x_cnt_r, .y_cnt_r, .busy_r,
    .fill_we_r, .fill_plane_r, .fill_x_r, .fill_y_r, .fill_bit_r);
  rwp_host host (.ref_clk, .cmd_stb, .data_stb, .byte_in, .ram_access);
  ////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // step size in pixels for a 3-bit code
  function automatic int step(input logic [2:0] c);
    return (c > 3'h4) ? 200 : (8 << c);
  endfunction
  // expected value of the k-th pixel of a 200 x 200 raster fill
  function automatic logic pix(input int k);
    return pb[7] ^ 1'((k % 200 / step(pb[2:0])) % 2) ^
      1'((k / 200 / step(pb[6:4])) % 2);
  endfunction
  task print_verdict;
    $display("errors %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // every written pixel against the raster order and the pattern
  always @(negedge ref_clk) begin
    if (fill_we_r === 1'b1) begin
      chk(fill_x_r, 9'((wr - base) % 200));
      chk(fill_y_r, 9'((wr - base) / 200));
      chk(fill_bit_r, pix(wr - base));
      wr++;
    end
  end
  // hang guard
  initial begin
    #360000;
    fails++;
    print_verdict();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    pb = 8'h00;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(x_window_first_field_r, 9'h000);
    chk(x_window_last_field_r, 9'h015);
    chk(read_plane_r, 9'h000);
    chk(x_cnt_r, 9'h000);
    chk(y_cnt_r, 9'h000);
    host.send(8'h41, 32'h0000_0001, 1);
    chk(read_plane_r, 9'h001);
    host.send(8'h44, 32'h0000_3AC5, 2);
    chk(x_window_first_field_r, 9'h005);
    chk(x_window_last_field_r, 9'h03A);
    host.send(8'h45, 32'h01C7_032C, 4);
    chk(y_window_first_r, 9'h12C);
    chk(y_window_last_r, 9'h1C7);
    host.send(8'h4E, 32'h0000_003A, 1);
    chk(x_cnt_r, 9'h03A);
    host.send(8'h4F, 32'h0000_01C7, 2);
    chk(y_cnt_r, 9'h1C7);
    host.touch();
    host.idle();
    chk(x_cnt_r, 9'h005);
    chk(y_cnt_r, 9'h12C);
    host.touch();
    host.idle();
    chk(x_cnt_r, 9'h006);
    chk(y_cnt_r, 9'h12C);
    for (int k = 0; k < 2; k++) begin
      pb = k ? 8'h43 : 8'hA5;
      base = wr;
      host.send(k ? 8'h47 : 8'h46, {24'h00_0000, pb}, 1);
      chk(busy_r, 9'h001);
      chk(fill_plane_r, k ? 9'h000 : 9'h001);
      host.send(8'h44, 32'h0000_0101, 2);
      host.touch();
      host.idle();
      n = 0;
      while (busy_r === 1'b1 && n < 41000) begin
        @(negedge ref_clk);
        n++;
      end
      chk(busy_r, 9'h000);
      chk(9'((wr - base) / 200), 9'h0C8);
      chk(9'((wr - base) % 200), 9'h000);
      chk(x_window_first_field_r, 9'h005);
      chk(x_cnt_r, 9'h006);
    end
    print_verdict();
  end
endmodule
